// [rtl/lfo_watchdog_defs.vh]
// Constants for the low-frequency-oscillator watchdog: register map, field positions,
// reset values and timing counts.
// Assumes it is included by bare name into each design file that needs it.
`ifndef LFO_WATCHDOG_DEFS_VH
`define LFO_WATCHDOG_DEFS_VH

// ==========================================================
// Register byte offsets (low address bits only)
`define CTRL_OFFSET          8'h00
`define RESTART_OFFSET       8'h04
`define STATUS_OFFSET        8'h08
`define COUNT_OFFSET         8'h0c
`define ADDR_DECODE_WIDTH    8

// ==========================================================
// Control register fields
`define CTRL_ENABLE_BIT      0
`define CTRL_LOCK_BIT        1
`define CTRL_SEL_LSB         4
`define CTRL_SEL_MSB         5

// ==========================================================
// Status register fields
`define STATUS_ENABLED_BIT   0
`define STATUS_LOCKED_BIT    1
`define STATUS_OVERFLOW_BIT  2
`define STATUS_REFUSED_BIT   3
`define STATUS_SEL_LSB       4
`define STATUS_SEL_MSB       5

// ==========================================================
// Restart key and reset values
`define RESTART_KEY          8'ha5
`define SEL_WIDTH            2
`define SEL_RESET            2'h3
`define ENABLE_RESET         1'b1
`define LOCK_RESET           1'b0

// ==========================================================
// Interval: terminal count is 2**(BASE + STEP*sel) - 1, so a timeout takes 2**(BASE + STEP*sel) oscillator ticks
`define INTERVAL_BASE_SHIFT  10
`define INTERVAL_STEP_SHIFT  2
`define COUNT_WIDTH          24

// ==========================================================
// Timing
`define CLOCK_PERIOD_NS      50
`define RESET_PULSE_NS       800
`define RESET_PULSE_CYCLES   ((`RESET_PULSE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define PULSE_CNT_WIDTH      5

`endif

// [rtl/lfo_tick_sync.v]
// Synchroniser and edge detector for the low-frequency oscillator input.
// Assumes the oscillator is far slower than clock_i, so each rising edge is seen as one tick.
`timescale 1ns/1ps

module lfo_tick_sync (
  input  wire clock_i,
  input  wire reset_n_i,
  input  wire lfo_clk_i,
  output wire tick_o
);

  reg sync1_reg;
  reg sync2_reg;
  reg sync3_reg;
  reg level_reg;
  reg tick_reg;

  // ==========================================================
  // Three stages; a change counts once stages two and three agree
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      level_reg <= 1'b0;
      tick_reg  <= 1'b0;
    end else begin
      sync1_reg <= lfo_clk_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg) begin
        level_reg <= sync3_reg;
      end
      tick_reg <= (sync2_reg == sync3_reg) && sync3_reg && !level_reg;
    end
  end

  assign tick_o = tick_reg;

endmodule // lfo_tick_sync

// [rtl/independent_lfo_watchdog.v]
// Watchdog timer counting low-frequency oscillator ticks, with an AHB-Lite register slave.
// The counter runs in the clock_i domain and advances on synchronised oscillator ticks.
// Assumes one AHB-Lite master, hreadyout_o fed back as hready_i, and that the system
// reset controller acts on system_reset_req_o without driving the external reset pin.
`timescale 1ns/1ps
`include "lfo_watchdog_defs.vh"

module independent_lfo_watchdog #(
  parameter COUNT_W     = `COUNT_WIDTH,
  parameter BASE_SHIFT  = `INTERVAL_BASE_SHIFT,
  parameter STEP_SHIFT  = `INTERVAL_STEP_SHIFT,
  parameter PULSE_W     = `PULSE_CNT_WIDTH
) (
  input  wire        clock_i,
  input  wire        reset_n_i,
  input  wire        lfo_clk_i,
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output wire [31:0] hrdata_o,
  output wire        hreadyout_o,
  output wire        hresp_o,
  output wire        system_reset_req_o,
  output wire        enabled_o,
  output wire        locked_o
);

  localparam integer       AW               = `ADDR_DECODE_WIDTH;
  localparam integer       SW               = `SEL_WIDTH;
  localparam integer       PULSE_CYCLES_INT = `RESET_PULSE_CYCLES;
  localparam [PULSE_W-1:0] PULSE_CYCLES     = PULSE_CYCLES_INT[PULSE_W-1:0];
  localparam [PULSE_W-1:0] PULSE_ONE        = {{(PULSE_W-1){1'b0}}, 1'b1};
  localparam [COUNT_W-1:0] COUNT_ONE        = {{(COUNT_W-1){1'b0}}, 1'b1};

  // ==========================================================
  // Oscillator tick
  wire lfo_tick;

  lfo_tick_sync u_lfo_tick_sync (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .lfo_clk_i (lfo_clk_i),
    .tick_o    (lfo_tick)
  );

  // ==========================================================
  // State
  reg               enable_reg;
  reg               lock_reg;
  reg [SW-1:0]      sel_reg;
  reg [COUNT_W-1:0] count_reg;
  reg               overflow_flag_reg;
  reg               refused_flag_reg;
  reg [PULSE_W-1:0] pulse_cnt_reg;
  reg               reset_req_reg;

  reg               wr_pend_reg;
  reg [AW-1:0]      wr_addr_reg;
  reg               rd_late_reg;
  reg [AW-1:0]      rd_addr_reg;
  reg [31:0]        hrdata_reg;
  reg               hreadyout_reg;
  reg               hresp_reg;

  reg               enable_next;
  reg               lock_next;
  reg [SW-1:0]      sel_next;
  reg [COUNT_W-1:0] count_next;
  reg               overflow_flag_next;
  reg               refused_flag_next;
  reg [PULSE_W-1:0] pulse_cnt_next;

  // ==========================================================
  // Terminal count for an interval choice
  function [COUNT_W-1:0] terminal_count;
    input [SW-1:0] sel;
    reg   [COUNT_W-1:0] one_hot;
    begin
      one_hot = COUNT_ONE << (BASE_SHIFT + STEP_SHIFT * sel);
      terminal_count = one_hot - COUNT_ONE;
    end
  endfunction

  // ==========================================================
  // Register images presented to reads
  reg [31:0] ctrl_image;
  reg [31:0] status_image;
  reg [31:0] count_image;

  always @* begin
    ctrl_image                              = 32'h0000_0000;
    ctrl_image[`CTRL_ENABLE_BIT]            = enable_reg;
    ctrl_image[`CTRL_LOCK_BIT]              = lock_reg;
    ctrl_image[`CTRL_SEL_MSB:`CTRL_SEL_LSB] = sel_reg;
  end

  always @* begin
    status_image                                  = 32'h0000_0000;
    status_image[`STATUS_ENABLED_BIT]             = enable_reg;
    status_image[`STATUS_LOCKED_BIT]              = lock_reg;
    status_image[`STATUS_OVERFLOW_BIT]            = overflow_flag_reg;
    status_image[`STATUS_REFUSED_BIT]             = refused_flag_reg;
    status_image[`STATUS_SEL_MSB:`STATUS_SEL_LSB] = sel_reg;
  end

  always @* begin
    count_image              = 32'h0000_0000;
    count_image[COUNT_W-1:0] = count_reg;
  end

  // ==========================================================
  // Read multiplexer
  function [31:0] read_value;
    input [AW-1:0] addr;
    reg   [31:0]   value;
    begin
      case (addr)
        `CTRL_OFFSET:   value = ctrl_image;
        `STATUS_OFFSET: value = status_image;
        `COUNT_OFFSET:  value = count_image;
        default:        value = 32'h0000_0000;
      endcase
      read_value = value;
    end
  endfunction

  // ==========================================================
  // Bus decode
  wire bus_access  = hsel_i && htrans_i[1] && hready_i;
  wire wr_ctrl     = wr_pend_reg && (wr_addr_reg == `CTRL_OFFSET);
  wire wr_restart  = wr_pend_reg && (wr_addr_reg == `RESTART_OFFSET);
  wire wr_status   = wr_pend_reg && (wr_addr_reg == `STATUS_OFFSET);
  wire key_ok      = (hwdata_i[7:0] == `RESTART_KEY);
  wire restart_now = wr_restart && key_ok;

  // Control write fields; a locked block refuses the whole write
  wire          ctrl_accept  = wr_ctrl && !lock_reg;
  wire          ctrl_refuse  = wr_ctrl && lock_reg;
  wire          new_lock     = hwdata_i[`CTRL_LOCK_BIT];
  wire          new_enable   = hwdata_i[`CTRL_ENABLE_BIT] || new_lock;
  wire [SW-1:0] new_sel      = hwdata_i[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
  wire          clr_overflow = wr_status && hwdata_i[`STATUS_OVERFLOW_BIT];
  wire          clr_refused  = wr_status && hwdata_i[`STATUS_REFUSED_BIT];

  // ==========================================================
  // Overflow detect
  // A restart or an accepted control write in the tick's cycle wins over the overflow
  wire [COUNT_W-1:0] terminal     = terminal_count(sel_reg);
  wire               at_terminal  = (count_reg == terminal);
  wire               overflow_now = enable_reg && lfo_tick && at_terminal && !restart_now && !ctrl_accept;

  // ==========================================================
  // Next-state logic
  always @* begin
    enable_next        = enable_reg;
    lock_next          = lock_reg;
    sel_next           = sel_reg;
    count_next         = count_reg;
    overflow_flag_next = overflow_flag_reg;
    refused_flag_next  = refused_flag_reg;
    pulse_cnt_next     = pulse_cnt_reg;

    if (clr_overflow) begin
      overflow_flag_next = 1'b0;
    end
    if (clr_refused) begin
      refused_flag_next = 1'b0;
    end

    if (ctrl_refuse) begin
      refused_flag_next = 1'b1;
    end
    if (ctrl_accept) begin
      enable_next = new_enable;
      lock_next   = new_lock;
      sel_next    = new_sel;
    end

    // A disabled watchdog holds zero, so enabling always starts a full interval
    if (!enable_reg) begin
      count_next = {COUNT_W{1'b0}};
    end else if (restart_now || ctrl_accept) begin
      count_next = {COUNT_W{1'b0}};
    end else if (lfo_tick) begin
      count_next = count_reg + COUNT_ONE;
    end

    if (pulse_cnt_reg != {PULSE_W{1'b0}}) begin
      pulse_cnt_next = pulse_cnt_reg - PULSE_ONE;
    end

    // Overflow reinitialises enable, lock, sel and count as the device reset would
    if (overflow_now) begin
      enable_next        = `ENABLE_RESET;
      lock_next          = `LOCK_RESET;
      sel_next           = `SEL_RESET;
      count_next         = {COUNT_W{1'b0}};
      overflow_flag_next = 1'b1;
      pulse_cnt_next     = PULSE_CYCLES;
    end
  end

  // ==========================================================
  // Control registers
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      enable_reg <= `ENABLE_RESET;
      lock_reg   <= `LOCK_RESET;
      sel_reg    <= `SEL_RESET;
    end else begin
      enable_reg <= enable_next;
      lock_reg   <= lock_next;
      sel_reg    <= sel_next;
    end
  end

  // ==========================================================
  // Interval counter
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_reg <= {COUNT_W{1'b0}};
    end else begin
      count_reg <= count_next;
    end
  end

  // ==========================================================
  // Sticky status flags
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      overflow_flag_reg <= 1'b0;
      refused_flag_reg  <= 1'b0;
    end else begin
      overflow_flag_reg <= overflow_flag_next;
      refused_flag_reg  <= refused_flag_next;
    end
  end

  // ==========================================================
  // Internal reset request: a fixed pulse, never routed to the external reset pin
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pulse_cnt_reg <= {PULSE_W{1'b0}};
      reset_req_reg <= 1'b0;
    end else begin
      pulse_cnt_reg <= pulse_cnt_next;
      reset_req_reg <= (pulse_cnt_next != {PULSE_W{1'b0}});
    end
  end

  // ==========================================================
  // AHB-Lite slave: zero-wait reads, one wait for a read right after a write
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_pend_reg   <= 1'b0;
      wr_addr_reg   <= {AW{1'b0}};
      rd_late_reg   <= 1'b0;
      rd_addr_reg   <= {AW{1'b0}};
      hrdata_reg    <= 32'h0000_0000;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end else begin
      // Every transfer is answered OKAY
      hresp_reg   <= 1'b0;
      wr_pend_reg <= 1'b0;
      rd_late_reg <= 1'b0;
      if (rd_late_reg) begin
        hrdata_reg    <= read_value(rd_addr_reg);
        hreadyout_reg <= 1'b1;
      end else if (bus_access) begin
        if (hwrite_i) begin
          wr_pend_reg <= 1'b1;
          wr_addr_reg <= haddr_i[AW-1:0];
        end else if (wr_pend_reg) begin
          rd_late_reg   <= 1'b1;
          rd_addr_reg   <= haddr_i[AW-1:0];
          hreadyout_reg <= 1'b0;
        end else begin
          hrdata_reg <= read_value(haddr_i[AW-1:0]);
        end
      end
    end
  end

  assign hrdata_o           = hrdata_reg;
  assign hreadyout_o        = hreadyout_reg;
  assign hresp_o            = hresp_reg;
  assign system_reset_req_o = reset_req_reg;
  assign enabled_o          = enable_reg;
  assign locked_o           = lock_reg;

endmodule // independent_lfo_watchdog

// [testbench/watchdog_sva.sv]
// Assertion checker for the watchdog top module, bound to it below.
// Assumes the system reset request is not fed back into reset_n_i.
`timescale 1ns/1ps
module watchdog_sva (
  input wire        clock_i,
  input wire        reset_n_i,
  input wire        lfo_clk_i,
  input wire        hreadyout_o,
  input wire        hresp_o,
  input wire        system_reset_req_o,
  input wire        enabled_o,
  input wire        locked_o
);
  // ====
  // Cycles since the oscillator last rose
  reg       lfo_d;
  reg [3:0] since_lfo;
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lfo_d     <= 1'b0;
      since_lfo <= 4'hf;
    end else begin
      lfo_d <= lfo_clk_i;
      if (lfo_clk_i && !lfo_d)
        since_lfo <= 4'h0;
      else if (since_lfo != 4'hf)
        since_lfo <= since_lfo + 4'h1;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // ====
  // Properties
  hresp_okay_a: assert property (hresp_o == 1'b0) else $error("response not okay");
  single_wait_a: assert property (!hreadyout_o |=> hreadyout_o) else $error("wait over one cycle");
  reset_pulse_a: assert property ($rose(system_reset_req_o) |->
    system_reset_req_o[*8] ##1 system_reset_req_o[*8] ##1 !system_reset_req_o) else $error("bad pulse");
  lfo_cause_a: assert property ($rose(system_reset_req_o) |-> since_lfo <= 4'h9)
    else $error("overflow without tick");
  overflow_enabled_a: assert property ($rose(system_reset_req_o) |-> $past(enabled_o))
    else $error("overflow while disabled");
  overflow_reinit_a: assert property ($rose(system_reset_req_o) |-> enabled_o && !locked_o)
    else $error("no reinit");
  lock_enable_a: assert property (locked_o |-> enabled_o) else $error("locked but off");
  lock_hold_a: assert property ($fell(locked_o) |-> ##[0:1] $rose(system_reset_req_o))
    else $error("lock lost");
  locked_disable_a: assert property ($fell(enabled_o) |-> !$past(locked_o))
    else $error("disabled while locked");
endmodule // watchdog_sva

bind independent_lfo_watchdog watchdog_sva u_watchdog_sva (.clock_i(clock_i), .reset_n_i(reset_n_i),
  .lfo_clk_i(lfo_clk_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .system_reset_req_o(system_reset_req_o), .enabled_o(enabled_o), .locked_o(locked_o));

// [testbench/tb_top.sv]
// Self-checking bench for the watchdog: registers over AHB-Lite, oscillator from tasks.
// Assumes short intervals: sel n times out after 2**(2+n) ticks.
`timescale 1ns/1ps
`include "lfo_watchdog_defs.vh"
module tb_top;
  reg         clock_i = 1'b0;
  reg         reset_n_i = 1'b0;
  reg         lfo = 1'b0;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  wire [31:0] hrdata;
  wire        hready, hresp, req, enabled, locked;
  reg  [31:0] rd;
  int         fails = 0;
  int         comparisons = 0;
  always #25 clock_i = ~clock_i;
  independent_lfo_watchdog #(.BASE_SHIFT(2), .STEP_SHIFT(1)) u_independent_lfo_watchdog (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .lfo_clk_i(lfo), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .system_reset_req_o(req),
    .enabled_o(enabled), .locked_o(locked));
  // ====
  // Expectations and checking
  function automatic [31:0] status_of(input [3:0] flags, input [1:0] sel);
    return {26'h0, sel, flags};
  endfunction
  function automatic [31:0] ticks(input int sel);
    return 32'h1 << (2 + sel);
  endfunction
  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string name, input [31:0] seen, input [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // ====
  // Bus and oscillator drivers
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (hready !== 1'b1 && n < 40);
    if (hready !== 1'b1) begin
      fails++;
      summarize();
    end
  endtask
  task automatic xfer(input [7:0] a, input w, input [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rdc(input [7:0] a, input [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    check("read", rd, exp);
  endtask
  task automatic pins(input [2:0] exp);
    @(posedge clock_i);
    check("req locked enabled", {29'h0, req, locked, enabled}, {29'h0, exp});
  endtask
  task automatic lfo_ticks(input int n);
    repeat (n) begin
      lfo <= 1'b1;
      repeat (5) @(posedge clock_i);
      lfo <= 1'b0;
      repeat (5) @(posedge clock_i);
    end
  endtask
  task automatic do_reset();
    reset_n_i <= 1'b0;
    repeat (12) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
  endtask
  // ====
  // Scenarios
  initial begin
    int sel;
    reg [7:0] a;
    sel = $urandom(64);
    do_reset();
    rdc(`CTRL_OFFSET, status_of(4'h1, 2'h3));
    rdc(`STATUS_OFFSET, status_of(4'h1, 2'h3));
    pins(3'b001);
    repeat (100) @(posedge clock_i);
    rdc(`COUNT_OFFSET, 32'h0);
    for (sel = 0; sel < 4; sel++) begin
      wr(`CTRL_OFFSET, status_of(4'h1, sel[1:0]));
      lfo_ticks(ticks(sel) - 1);
      rdc(`COUNT_OFFSET, ticks(sel) - 1);
      wr(`RESTART_OFFSET, ($urandom & 32'hffffff00) | 32'ha5);
      rdc(`COUNT_OFFSET, 32'h0);
      lfo_ticks(1);
      wr(`RESTART_OFFSET, ($urandom & 32'hffffff00) | 32'h5a);
      lfo_ticks(ticks(sel) - 2);
      rdc(`COUNT_OFFSET, ticks(sel) - 1);
      pins(3'b001);
      lfo_ticks(1);
      pins(3'b101);
      rdc(`STATUS_OFFSET, status_of(4'h5, 2'h3));
      wr(`STATUS_OFFSET, 32'h4);
      repeat (20) @(posedge clock_i);
    end
    wr(`CTRL_OFFSET, status_of(4'h0, 2'h0));
    pins(3'b000);
    lfo_ticks(8);
    rdc(`COUNT_OFFSET, 32'h0);
    pins(3'b000);
    wr(`CTRL_OFFSET, status_of(4'h2, 2'h0));
    pins(3'b011);
    wr(`CTRL_OFFSET, status_of(4'h0, 2'h1));
    pins(3'b011);
    rdc(`STATUS_OFFSET, status_of(4'hb, 2'h0));
    wr(`STATUS_OFFSET, 32'h8);
    rdc(`STATUS_OFFSET, status_of(4'h3, 2'h0));
    lfo_ticks(2);
    rdc(`COUNT_OFFSET, 32'h2);
    wr(`RESTART_OFFSET, 32'ha5);
    rdc(`COUNT_OFFSET, 32'h0);
    a = 8'h10 + 8'(4 * ($urandom % 60));
    wr(a, $urandom);
    rdc(a, 32'h0);
    do_reset();
    pins(3'b001);
    rdc(`CTRL_OFFSET, status_of(4'h1, 2'h3));
    summarize();
  end
endmodule // tb_top
